// file: src/charger_pkg.sv
// constants, encodings and types shared by the setpoint decoder files
package charger_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h09;
  localparam logic [7:0] CMD_CHG_CURRENT = 8'h14;
  localparam logic [7:0] CMD_CHG_VOLTAGE = 8'h15;
  localparam logic [7:0] CMD_INPUT_LIMIT = 8'h3f;
  localparam int V_DROP_BITS = 4;
  localparam int V_DAC_W = 11;
  localparam int I_DROP_BITS = 7;
  localparam int I_DAC_W = 6;
  localparam logic [15:0] V_MAX_MV = 16'h4b00;
  localparam logic [15:0] V_MIN_MV = 16'h0400;
  localparam logic [15:0] I_MAX_MA = 16'h1f80;
  localparam logic [15:0] I_MIN_MA = 16'h0080;
  localparam logic [15:0] IN_MAX_MA = 16'h2afc;
  localparam logic [15:0] IN_MIN_MA = 16'h0100;
  localparam logic [15:0] CHG_VOLTAGE_POR = 16'h0000;
  localparam logic [15:0] CHG_CURRENT_POR = 16'h0080;
  localparam logic [15:0] INPUT_LIMIT_POR = 16'h0100;
  localparam logic [15:0] UV_ENTER_MV = 16'h09c4;
  localparam logic [15:0] UV_EXIT_MV = 16'h0a8c;
  localparam logic [5:0] UV_CURRENT_CODE = 6'h01;
  localparam logic [14:0] LIMIT_GAIN = 15'h0005;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  localparam int CLK_PERIOD_NS = 25;
  localparam int THROTTLE_STEP_NS = 1000;
  localparam int THROTTLE_CYC = THROTTLE_STEP_NS / CLK_PERIOD_NS;
  localparam int THR_CNT_W = 6;
  localparam int MV_W = 12;
  localparam int WIDE_W = 16;
  localparam logic [15:0] RELEARN_END_MV = 16'h2328;

  typedef enum logic [5:0] {
    PH_IDLE = 6'b000001,
    PH_ADDR = 6'b000010,
    PH_CMD = 6'b000100,
    PH_LO = 6'b001000,
    PH_HI = 6'b010000,
    PH_WAIT = 6'b100000
  } phase_t;

  typedef enum logic [2:0] {
    LOOP_CURRENT = 3'b001,
    LOOP_VOLTAGE = 3'b010,
    LOOP_INPUT = 3'b100
  } loop_t;

  typedef enum logic [2:0] {
    RL_IDLE = 3'b001,
    RL_DISCHARGE = 3'b010,
    RL_RECHARGE = 3'b100
  } relearn_t;
endpackage

// file: src/setpoint_if.sv
// completed write-word transfers passed from the bus slave to the setpoint logic
interface setpoint_if;
  logic word_valid;
  logic [7:0] cmd;
  logic [15:0] data;
  logic ack;
  modport slave (output word_valid, output cmd, output data, output ack);
  modport sink (input word_valid, input cmd, input data, input ack);
endinterface

// file: src/smbus_word_slave.sv
// two-wire write-word slave: receives address, command and two data bytes
module smbus_word_slave (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  setpoint_if.slave sp
);
  logic [2:0] scl_s_r, sda_s_r;
  logic scl_f_r, sda_f_r, scl_new, sda_new;
  logic rise, fall, start, stop;
  charger_pkg::phase_t phase_r, phase_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, cmd_r, cmd_nxt;
  logic [15:0] data_r, data_nxt;
  logic ack_r, ack_nxt, full_r, full_nxt, valid_r, valid_nxt;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
      scl_f_r <= scl_new;
      sda_f_r <= sda_new;
    end
  end

  always_comb begin
    scl_new = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
    sda_new = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
    rise = scl_new & ~scl_f_r;
    fall = ~scl_new & scl_f_r;
    start = scl_f_r & scl_new & sda_f_r & ~sda_new;
    stop = scl_f_r & scl_new & ~sda_f_r & sda_new;
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    cmd_nxt = cmd_r;
    data_nxt = data_r;
    ack_nxt = ack_r;
    full_nxt = full_r;
    valid_nxt = 1'b0;
    if (start) begin
      phase_nxt = charger_pkg::PH_ADDR;
      cnt_nxt = 4'h0;
      ack_nxt = 1'b0;
      full_nxt = 1'b0;
    end else if (stop) begin
      valid_nxt = full_r;
      phase_nxt = charger_pkg::PH_IDLE;
      cnt_nxt = 4'h0;
      ack_nxt = 1'b0;
      full_nxt = 1'b0;
    end else if (phase_r != charger_pkg::PH_IDLE) begin
      if (rise && cnt_r < charger_pkg::BITS_PER_BYTE) begin
        sh_nxt = {sh_r[6:0], sda_new};
        cnt_nxt = cnt_r + 4'h1;
      end else if (fall && cnt_r == charger_pkg::BITS_PER_BYTE) begin
        cnt_nxt = charger_pkg::ACK_SLOT;
        case (phase_r)
          charger_pkg::PH_ADDR: ack_nxt = (sh_r == {charger_pkg::SLAVE_ADDR, 1'b0});
          charger_pkg::PH_CMD: begin
            cmd_nxt = sh_r;
            ack_nxt = (sh_r == charger_pkg::CMD_CHG_CURRENT) ||
                      (sh_r == charger_pkg::CMD_CHG_VOLTAGE) ||
                      (sh_r == charger_pkg::CMD_INPUT_LIMIT);
          end
          charger_pkg::PH_LO: begin
            data_nxt[7:0] = sh_r;
            ack_nxt = 1'b1;
          end
          charger_pkg::PH_HI: begin
            data_nxt[15:8] = sh_r;
            ack_nxt = 1'b1;
          end
          default: begin
            ack_nxt = 1'b0;
            full_nxt = 1'b0;
          end
        endcase
      end else if (fall && cnt_r == charger_pkg::ACK_SLOT) begin
        cnt_nxt = 4'h0;
        ack_nxt = 1'b0;
        full_nxt = ack_r && (phase_r == charger_pkg::PH_HI);
        if (!ack_r) begin
          phase_nxt = charger_pkg::PH_IDLE;
        end else begin
          case (phase_r)
            charger_pkg::PH_ADDR: phase_nxt = charger_pkg::PH_CMD;
            charger_pkg::PH_CMD: phase_nxt = charger_pkg::PH_LO;
            charger_pkg::PH_LO: phase_nxt = charger_pkg::PH_HI;
            default: phase_nxt = charger_pkg::PH_WAIT;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_r <= charger_pkg::PH_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      cmd_r <= 8'h00;
      data_r <= 16'h0000;
      ack_r <= 1'b0;
      full_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      cmd_r <= cmd_nxt;
      data_r <= data_nxt;
      ack_r <= ack_nxt;
      full_r <= full_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign sp.word_valid = valid_r;
  assign sp.cmd = cmd_r;
  assign sp.data = data_r;
  assign sp.ack = ack_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  AST_VALID_AFTER_STOP: assert property (valid_r |-> $past(full_r) && $past(stop))
    else $error("word committed without a complete acknowledged transfer");
  AST_ACK_ONLY_IN_SLOT: assert property (ack_r |-> cnt_r == charger_pkg::ACK_SLOT)
    else $error("acknowledge driven outside the ninth clock");
endmodule // smbus_word_slave

// file: src/charger_setpoint_decoder.sv
// setpoint decoder of a smart battery charger: bus words to DAC codes and loop control
//
// What this block does
// - voltage word is millivolts; drop low 4 bits, next 11 bits drive voltage DAC
// - voltage requests above 19.200V are clamped to exactly 19.200V
// - voltage requests below 1.024V force a zero setpoint and stop charging
// - current word is 1mA per step; drop low 7 bits, next 6 drive current DAC
// - current requests above 8.064A saturate at 8.064A
// - current requests from 1mA to 128mA give a 128mA setting
// - after reset the charge-current setpoint is 128mA until rewritten
// - input word is 1mA per step; drop low 7 bits, next 6 drive input DAC
// - input-limit requests above 11.004A saturate at 11.004A
// - input-limit requests from 1mA to 256mA give a 256mA setting
// - after reset the input-limit setpoint is 256mA until rewritten
// - effective voltage is the lesser of setpoint and five times the voltage limit input
// - effective current is the lesser of setpoint and five amperes per volt of limit input
// - current loop governs below the voltage setpoint, voltage loop once reached
// - input loop takes over above the input limit and lowers charge current
// - system source chosen from adapter presence via load and source switch drives
// - relearn on request: isolate battery, discharge through load, then recharge
// - battery below 2.5V caps current at 128mA, word kept; resumes above 2.7V
// - device answers only at bus address 0b0001001
module charger_setpoint_decoder #(
  parameter logic [15:0] RELEARN_END_MV = charger_pkg::RELEARN_END_MV
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [11:0] max_voltage_limit_in_i,
  input wire logic [11:0] max_current_limit_in_i,
  input wire logic [15:0] battery_sense_in_i,
  input wire logic [15:0] input_current_meas_i,
  input wire logic adapter_supply_in_i,
  input wire logic relearn_req_i,
  output logic [10:0] voltage_dac_o,
  output logic [5:0] charge_dac_o,
  output logic [5:0] input_dac_o,
  output logic voltage_loop_comp_o,
  output logic charge_loop_comp_o,
  output logic input_loop_comp_o,
  output logic load_switch_drive_o,
  output logic source_switch_drive_o,
  output logic relearn_active_o,
  output logic battery_low_o
);
  localparam int SW = 2 * charger_pkg::MV_W + 2 * charger_pkg::WIDE_W + 2;

  setpoint_if sp ();
  smbus_word_slave u_slave (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sp(sp.slave)
  );

  // three-stage synchronisers; a bit changes once stages two and three agree
  logic [SW-1:0] raw;
  wire logic [SW-1:0] filt_w;
  assign raw = {max_voltage_limit_in_i, max_current_limit_in_i, battery_sense_in_i,
                input_current_meas_i, adapter_supply_in_i, relearn_req_i};
  genvar g;
  generate
    for (g = 0; g < SW; g++) begin : g_sync
      logic s1_r, s2_r, s3_r, filt_r;
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          filt_r <= 1'b0;
        end else begin
          s1_r <= raw[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          filt_r <= (s2_r == s3_r) ? s3_r : filt_r;
        end
      end
      assign filt_w[g] = filt_r;
    end
  endgenerate
  logic [11:0] max_voltage_limit_in_f, max_current_limit_in_f;
  logic [15:0] battery_sense_in_f, inmeas_f;
  logic adapter_f, req_f;
  assign {max_voltage_limit_in_f, max_current_limit_in_f, battery_sense_in_f, inmeas_f, adapter_f, req_f} = filt_w;

  // setpoint words, stored already clamped
  logic [15:0] v_word_r, v_word_nxt, i_word_r, i_word_nxt, in_word_r, in_word_nxt;
  logic [15:0] d;
  always_comb begin
    d = sp.data;
    v_word_nxt = v_word_r;
    i_word_nxt = i_word_r;
    in_word_nxt = in_word_r;
    if (sp.word_valid) begin
      case (sp.cmd)
        charger_pkg::CMD_CHG_VOLTAGE: begin
          if (d > charger_pkg::V_MAX_MV) v_word_nxt = charger_pkg::V_MAX_MV;
          else if (d < charger_pkg::V_MIN_MV) v_word_nxt = 16'h0000;
          else v_word_nxt = d;
        end
        charger_pkg::CMD_CHG_CURRENT: begin
          if (d > charger_pkg::I_MAX_MA) i_word_nxt = charger_pkg::I_MAX_MA;
          else if (d == 16'h0000) i_word_nxt = 16'h0000;
          else if (d <= charger_pkg::I_MIN_MA) i_word_nxt = charger_pkg::I_MIN_MA;
          else i_word_nxt = d;
        end
        charger_pkg::CMD_INPUT_LIMIT: begin
          if (d > charger_pkg::IN_MAX_MA) in_word_nxt = charger_pkg::IN_MAX_MA;
          else if (d <= charger_pkg::IN_MIN_MA) in_word_nxt = charger_pkg::IN_MIN_MA;
          else in_word_nxt = d;
        end
        default: v_word_nxt = v_word_r;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      v_word_r <= charger_pkg::CHG_VOLTAGE_POR;
      i_word_r <= charger_pkg::CHG_CURRENT_POR;
      in_word_r <= charger_pkg::INPUT_LIMIT_POR;
    end else begin
      v_word_r <= v_word_nxt;
      i_word_r <= i_word_nxt;
      in_word_r <= in_word_nxt;
    end
  end

  // DAC codes: truncation of the dropped low bits
  logic [10:0] v_code, max_voltage_limit_in_code, v_eff;
  logic [5:0] i_code, max_current_limit_in_code, in_code;
  logic [14:0] max_voltage_limit_in_mv, max_current_limit_in_ma;
  logic [15:0] in_lim_ma, v_set_mv;
  always_comb begin
    v_code = v_word_r[charger_pkg::V_DROP_BITS +: charger_pkg::V_DAC_W];
    i_code = i_word_r[charger_pkg::I_DROP_BITS +: charger_pkg::I_DAC_W];
    in_code = (in_word_r[15:13] != 3'h0) ? 6'h3f
              : in_word_r[charger_pkg::I_DROP_BITS +: charger_pkg::I_DAC_W];
    in_lim_ma = {in_word_r[15:7], 7'h00};
    max_voltage_limit_in_mv = 15'(max_voltage_limit_in_f * charger_pkg::LIMIT_GAIN);
    max_current_limit_in_ma = 15'(max_current_limit_in_f * charger_pkg::LIMIT_GAIN);
    max_voltage_limit_in_code = max_voltage_limit_in_mv[14:4];
    max_current_limit_in_code = (max_current_limit_in_ma[14:13] != 2'h0) ? 6'h3f : max_current_limit_in_ma[12:7];
    v_eff = (v_code < max_voltage_limit_in_code) ? v_code : max_voltage_limit_in_code;
    v_set_mv = {1'b0, v_eff, 4'h0};
  end

  // battery undervoltage with hysteresis
  logic uv_r, uv_nxt;
  always_comb begin
    uv_nxt = uv_r;
    if (battery_sense_in_f < charger_pkg::UV_ENTER_MV) uv_nxt = 1'b1;
    else if (battery_sense_in_f > charger_pkg::UV_EXIT_MV) uv_nxt = 1'b0;
  end

  // relearn sequencer and input-loop throttle
  charger_pkg::relearn_t rl_r, rl_nxt;
  charger_pkg::loop_t loop_nxt;
  logic req_d_r, in_over;
  logic [charger_pkg::THR_CNT_W-1:0] div_r, div_nxt;
  logic [5:0] thr_r, thr_nxt, c_lim, c_eff;
  logic tick;
  always_comb begin
    in_over = inmeas_f > in_lim_ma;
    if (in_over) loop_nxt = charger_pkg::LOOP_INPUT;
    else if (v_eff != 11'h000 && battery_sense_in_f >= v_set_mv)
      loop_nxt = charger_pkg::LOOP_VOLTAGE;
    else loop_nxt = charger_pkg::LOOP_CURRENT;
    tick = (div_r == charger_pkg::THR_CNT_W'(charger_pkg::THROTTLE_CYC - 1));
    div_nxt = tick ? '0 : div_r + 1'b1;
    c_lim = (i_code < max_current_limit_in_code) ? i_code : max_current_limit_in_code;
    if (uv_r && c_lim > charger_pkg::UV_CURRENT_CODE)
      c_lim = charger_pkg::UV_CURRENT_CODE;
    thr_nxt = thr_r;
    if (tick && in_over && thr_r < c_lim) thr_nxt = thr_r + 6'h01;
    else if (tick && !in_over && thr_r != 6'h00) thr_nxt = thr_r - 6'h01;
    c_eff = (thr_r < c_lim) ? c_lim - thr_r : 6'h00;
    rl_nxt = rl_r;
    case (rl_r)
      charger_pkg::RL_IDLE: if (req_f && !req_d_r) rl_nxt = charger_pkg::RL_DISCHARGE;
      charger_pkg::RL_DISCHARGE: if (battery_sense_in_f < RELEARN_END_MV) rl_nxt = charger_pkg::RL_RECHARGE;
      charger_pkg::RL_RECHARGE:
        if (loop_nxt == charger_pkg::LOOP_VOLTAGE) rl_nxt = charger_pkg::RL_IDLE;
      default: rl_nxt = charger_pkg::RL_IDLE;
    endcase
    if (rl_r == charger_pkg::RL_DISCHARGE || v_eff == 11'h000) c_eff = 6'h00;
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uv_r <= 1'b1;
      rl_r <= charger_pkg::RL_IDLE;
      req_d_r <= 1'b0;
      div_r <= '0;
      thr_r <= 6'h00;
    end else begin
      uv_r <= uv_nxt;
      rl_r <= rl_nxt;
      req_d_r <= req_f;
      div_r <= div_nxt;
      thr_r <= thr_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      voltage_dac_o <= 11'h000;
      charge_dac_o <= 6'h00;
      input_dac_o <= 6'h00;
      voltage_loop_comp_o <= 1'b0;
      charge_loop_comp_o <= 1'b0;
      input_loop_comp_o <= 1'b0;
      load_switch_drive_o <= 1'b0;
      source_switch_drive_o <= 1'b0;
      relearn_active_o <= 1'b0;
      battery_low_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= sp.ack;
      voltage_dac_o <= v_eff;
      charge_dac_o <= c_eff;
      input_dac_o <= in_code;
      voltage_loop_comp_o <= (loop_nxt == charger_pkg::LOOP_VOLTAGE);
      charge_loop_comp_o <= (loop_nxt == charger_pkg::LOOP_CURRENT);
      input_loop_comp_o <= (loop_nxt == charger_pkg::LOOP_INPUT);
      // adapter feeds the system; battery takes over without it or during the relearn discharge phase
      source_switch_drive_o <= adapter_f && rl_r != charger_pkg::RL_DISCHARGE;
      load_switch_drive_o <= !adapter_f || rl_r == charger_pkg::RL_DISCHARGE;
      relearn_active_o <= (rl_r != charger_pkg::RL_IDLE);
      battery_low_o <= uv_r;
    end
  end

  logic [1:0] seen_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) seen_r <= 2'b00;
    else if (sp.word_valid && sp.cmd == charger_pkg::CMD_CHG_CURRENT) seen_r[0] <= 1'b1;
    else if (sp.word_valid && sp.cmd == charger_pkg::CMD_INPUT_LIMIT) seen_r[1] <= 1'b1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence seq_vwrite;
    sp.word_valid && sp.cmd == charger_pkg::CMD_CHG_VOLTAGE;
  endsequence
  sequence seq_iwrite;
    sp.word_valid && sp.cmd == charger_pkg::CMD_CHG_CURRENT;
  endsequence
  sequence seq_inwrite;
    sp.word_valid && sp.cmd == charger_pkg::CMD_INPUT_LIMIT;
  endsequence

  AST_V_TRUNC: assert property (seq_vwrite ##0 (sp.data >= charger_pkg::V_MIN_MV &&
      sp.data <= charger_pkg::V_MAX_MV) |=> v_code == $past(sp.data[14:4]))
    else $error("voltage code is not the truncated word");
  AST_V_CLAMP: assert property (seq_vwrite ##0 sp.data > charger_pkg::V_MAX_MV
      |=> v_word_r == charger_pkg::V_MAX_MV)
    else $error("voltage above limit not clamped");
  AST_V_ZERO: assert property (seq_vwrite ##0 sp.data < charger_pkg::V_MIN_MV
      |=> v_word_r == 16'h0000 ##1 charge_dac_o == 6'h00)
    else $error("low voltage request did not stop charging");
  AST_I_CLAMP: assert property (seq_iwrite ##0 sp.data > charger_pkg::I_MAX_MA
      |=> i_code == 6'h3f)
    else $error("charge current not saturated");
  AST_I_FLOOR: assert property (seq_iwrite ##0 (sp.data != 16'h0000 &&
      sp.data <= charger_pkg::I_MIN_MA) |=> i_code == 6'h01)
    else $error("small charge current not raised to one step");
  AST_I_ZERO: assert property (seq_iwrite ##0 sp.data == 16'h0000
      |=> ##1 charge_dac_o == 6'h00)
    else $error("zero charge current word still charges");
  AST_IN_CLAMP: assert property (seq_inwrite ##0 sp.data > charger_pkg::IN_MAX_MA
      |=> in_word_r == charger_pkg::IN_MAX_MA ##1 input_dac_o == 6'h3f)
    else $error("input limit not saturated");
  AST_IN_FLOOR: assert property (seq_inwrite ##0 sp.data <= charger_pkg::IN_MIN_MA
      |=> in_word_r == charger_pkg::IN_MIN_MA)
    else $error("small input limit not raised to minimum");
  AST_POR_CURRENT: assert property (!seen_r[0]
      |-> i_word_r == charger_pkg::CHG_CURRENT_POR)
    else $error("charge current default lost");
  AST_POR_INPUT: assert property (!seen_r[1]
      |-> in_word_r == charger_pkg::INPUT_LIMIT_POR)
    else $error("input limit default lost");
  AST_MAX_VOLTAGE_LIMIT_IN: assert property (##1 voltage_dac_o <= $past(max_voltage_limit_in_code))
    else $error("voltage exceeds the external limit");
  AST_MAX_CURRENT_LIMIT_IN: assert property (##1 charge_dac_o <= $past(max_current_limit_in_code))
    else $error("current exceeds the external limit");
  AST_UV_CAP: assert property (uv_r |=> charge_dac_o <= charger_pkg::UV_CURRENT_CODE)
    else $error("undervoltage cap not applied");
  AST_VLOOP: assert property (!in_over && v_eff != 11'h000 && battery_sense_in_f >= v_set_mv
      |=> voltage_loop_comp_o && !charge_loop_comp_o)
    else $error("voltage loop not in control at setpoint");
  AST_INLOOP: assert property (in_over |=> input_loop_comp_o && !voltage_loop_comp_o)
    else $error("input loop did not take over");
  AST_SOURCE: assert property (rl_r == charger_pkg::RL_IDLE && adapter_f
      |=> source_switch_drive_o && !load_switch_drive_o)
    else $error("adapter present but source not selected");
  AST_RELEARN: assert property (rl_r == charger_pkg::RL_DISCHARGE
      |=> !source_switch_drive_o && load_switch_drive_o && charge_dac_o == 6'h00)
    else $error("battery not isolated during relearn discharge");
endmodule // charger_setpoint_decoder

// file: verif/smbus_host_model.sv
// bus host model that issues write-word transfers to the charger
module smbus_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released lines sit at the pull-up level
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hold();
    repeat (6) @(negedge clk_i);
  endtask
  // data changes only while the clock is low; the wire is sampled at the end of clock high
  task automatic clock_bit(input logic b, output logic seen);
    sda_o = b;
    hold();
    scl_o = 1'b1;
    hold();
    seen = sda_i;
    scl_o = 1'b0;
    hold();
  endtask
  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                            output logic [3:0] nacks);
    logic [31:0] frame;
    logic x;
    frame = {a, 1'b0, c, d[7:0], d[15:8]};
    sda_o = 1'b0;
    hold();
    scl_o = 1'b0;
    hold();
    for (int j = 0; j < 4; j++) begin
      for (int i = 7; i >= 0; i--) begin
        clock_bit(frame[31 - 8 * j - (7 - i)], x);
      end
      clock_bit(1'b1, nacks[3 - j]);
    end
    sda_o = 1'b0;
    hold();
    scl_o = 1'b1;
    hold();
    sda_o = 1'b1;
    hold();
  endtask
endmodule // smbus_host_model

// file: verif/charger_setpoint_decoder_test.sv
// self-checking bench for the charger setpoint decoder
module charger_setpoint_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rstn_i = 1'b0, adp = 1'b1, rl = 1'b0, scl, sda_h, sda_oe, sda_x;
  logic [11:0] max_voltage_limit_in = 12'hfff, max_current_limit_in = 12'hfff;
  logic [15:0] battery_sense_in = 16'h0c00, meas = 16'h0000, w;
  logic [10:0] vdac;
  logic [5:0] cdac, idac;
  logic vl, cl, il, ls, ss, ra, bl;
  logic [3:0] acks;
  int fails = 0, cmp_count = 0;
  wire logic sda_w = sda_h & ~sda_oe;
  logic [15:0] corner [3][6] = '{'{16'h4b00, 16'h4b01, 16'hffff, 16'h03ff, 16'h0400, 16'h123f},
    '{16'h0000, 16'h0001, 16'h0080, 16'h0100, 16'h1f80, 16'h1f81},
    '{16'h0000, 16'h0100, 16'h017f, 16'h0180, 16'h2afc, 16'h2afd}};
  always #12.5 clk_i = ~clk_i;
  charger_setpoint_decoder dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_x), .sda_oe_o(sda_oe), .max_voltage_limit_in_i(max_voltage_limit_in),
    .max_current_limit_in_i(max_current_limit_in), .battery_sense_in_i(battery_sense_in), .input_current_meas_i(meas),
    .adapter_supply_in_i(adp), .relearn_req_i(rl), .voltage_dac_o(vdac), .charge_dac_o(cdac),
    .input_dac_o(idac), .voltage_loop_comp_o(vl), .charge_loop_comp_o(cl),
    .input_loop_comp_o(il), .load_switch_drive_o(ls), .source_switch_drive_o(ss),
    .relearn_active_o(ra), .battery_low_o(bl));
  smbus_host_model host_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
  function automatic logic [15:0] ev(input logic [15:0] v);
    if (v > charger_pkg::V_MAX_MV) return charger_pkg::V_MAX_MV >> charger_pkg::V_DROP_BITS;
    return v < charger_pkg::V_MIN_MV ? 16'h0000 : {5'h00, v[14:4]};
  endfunction
  function automatic logic [15:0] ei(input logic [15:0] v);
    if (v == 16'h0000) return 16'h0000;
    if (v <= charger_pkg::I_MIN_MA) return 16'h0001;
    return v > charger_pkg::I_MAX_MA ? 16'h003f : {10'h000, v[12:7]};
  endfunction
  function automatic logic [15:0] en(input logic [15:0] v);
    if (v <= charger_pkg::IN_MIN_MA) return 16'h0002;
    return v[15:13] != 3'h0 ? 16'h003f : {10'h000, v[12:7]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic [6:0] a = 7'h09,
                    input logic [3:0] e = 4'h0);
    host_u.write_word(a, c, d, acks);
    tick(4);
    chk({11'h000, sda_x, acks}, {12'h000, e});
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_i);
    fails++;
    test_done();
  end
  initial begin
    void'($urandom(32'h98bf5917));
    tick(6);
    rstn_i = 1'b1;
    tick(10);
    chk({10'h000, idac}, 16'h0002);
    wr(charger_pkg::CMD_CHG_VOLTAGE, 16'h3000);
    chk({10'h000, cdac}, 16'h0001);
    for (int k = 0; k < 36; k++) begin
      w = k % 12 < 6 ? corner[k / 12][k % 12] : 16'($urandom);
      if (k < 12) begin
        wr(charger_pkg::CMD_CHG_VOLTAGE, w);
        chk({5'h00, vdac}, ev(w));
        if (k == 11) wr(charger_pkg::CMD_CHG_VOLTAGE, 16'h4000);
      end else if (k < 24) begin
        wr(charger_pkg::CMD_CHG_CURRENT, w);
        chk({10'h000, cdac}, ei(w));
      end else begin
        wr(charger_pkg::CMD_INPUT_LIMIT, w);
        chk({10'h000, idac}, en(w));
      end
    end
    wr(charger_pkg::CMD_INPUT_LIMIT, 16'h0400);
    wr(charger_pkg::CMD_INPUT_LIMIT, 16'h0200, 7'h0a, 4'hf);
    wr(8'h16, 16'h0200, 7'h09, 4'h7);
    chk({10'h000, idac}, 16'h0008);
    max_voltage_limit_in = 12'h400;
    max_current_limit_in = 12'h100;
    wr(charger_pkg::CMD_CHG_CURRENT, 16'h1f80);
    chk({5'h00, vdac}, 16'd320);
    chk({10'h000, cdac}, 16'd10);
    max_voltage_limit_in = 12'hfff;
    max_current_limit_in = 12'hfff;
    battery_sense_in = 16'h0800;
    tick(12);
    chk({14'h0000, bl, cdac == 6'h01}, 16'h0003);
    battery_sense_in = 16'h0a8c;
    tick(12);
    chk({15'h0000, bl}, 16'h0001);
    battery_sense_in = 16'h0c00;
    tick(12);
    chk({9'h000, bl, cdac}, 16'h003f);
    chk({13'h0000, vl, cl, il}, 16'h0002);
    battery_sense_in = 16'h4000;
    tick(12);
    chk({13'h0000, vl, cl, il}, 16'h0004);
    battery_sense_in = 16'h0c00;
    meas = 16'h1000;
    tick(300);
    chk({14'h0000, il, cdac < 6'h3f}, 16'h0003);
    meas = 16'h0000;
    chk({14'h0000, ss, ls}, 16'h0002);
    adp = 1'b0;
    tick(12);
    chk({14'h0000, ss, ls}, 16'h0001);
    adp = 1'b1;
    // battery starts above the end-of-discharge level so the discharge phase is visible
    battery_sense_in = 16'h3000;
    tick(12);
    rl = 1'b1;
    tick(12);
    chk({7'h00, ra, ss, ls, cdac}, 16'h0140);
    battery_sense_in = 16'h0c00;
    tick(12);
    chk({13'h0000, ra, ss, cdac != 6'h00}, 16'h0007);
    battery_sense_in = 16'h4000;
    tick(12);
    chk({14'h0000, ra, vl}, 16'h0001);
    test_done();
  end
endmodule // charger_setpoint_decoder_test
